// *** hw/llpe_pkg.sv ***
// Constants and types shared by the link-layer performance event block.
// Summary of operation
// - Tick event code adds one per cycle
// - Tick rate is one eighth of transfer
// - Trigger-out event adds per triggering slot
// - Slots fire from packet match and mask
// - Spawn event counts only candidate response packets
// - Umask bit zero selects successful spawns
// - Umask bits one two four: single failures
// - Umask bits three five six seven: combined failures
// - Shutdown code counts cycles, edge counts entries
// - Power state tracked per direction
// - Half-width code counts receive reduced-width cycles
// - Half-width edge counts unreliable after shutdown
// - Full-operation code counts receive full cycles
// - Full-operation count includes half-width cycles
// - Buffer-skip code counts bypassed flits
// - Credit code adds up to two per cycle
// - Credit umask bits select six message classes
// - Only counters zero to three; umask bits 15:8
package llpe_pkg;

   // ------------------------------------------------------------
   // Event codes
   // ------------------------------------------------------------
   localparam logic [7:0] CODE_TICK      = 8'h14;
   localparam logic [7:0] CODE_TRIGGER   = 8'h38;
   localparam logic [7:0] CODE_SPAWN     = 8'h13;
   localparam logic [7:0] CODE_OFF       = 8'h12;
   localparam logic [7:0] CODE_HALF      = 8'h10;
   localparam logic [7:0] CODE_FULL      = 8'h0f;
   localparam logic [7:0] CODE_SKIP      = 8'h09;
   localparam logic [7:0] CODE_CREDIT    = 8'h1e;

   // ------------------------------------------------------------
   // Register map (byte addresses) and select fields
   // ------------------------------------------------------------
   localparam int         NUM_CTR        = 4;
   localparam logic [7:0] ADDR_SEL0      = 8'h00;
   localparam logic [7:0] ADDR_CTR0      = 8'h10;
   localparam logic [7:0] ADDR_FILT0     = 8'h20;
   localparam logic [7:0] ADDR_STATUS    = 8'h30;
   localparam int         SEL_CODE_LSB   = 0;
   localparam int         SEL_UMASK_LSB  = 8;
   localparam int         SEL_EDGE_BIT   = 18;
   localparam int         SEL_EN_BIT     = 22;
   localparam int         SEL_EXT_BIT    = 21;
   localparam logic [31:0] SEL_RESET     = 32'h0000_0000;
   localparam logic [31:0] CTR_RESET     = 32'h0000_0000;
   localparam logic [31:0] FILT_RESET    = 32'h0000_0000;

   // ------------------------------------------------------------
   // Filter field widths and offset, link clock divide ratio
   // ------------------------------------------------------------
   localparam int FIRST_W  = 18;
   localparam int SECOND_LSB = 16;
   localparam int SECOND_W = 4;
   localparam int LINK_DIV = 8;

   // ------------------------------------------------------------
   // Receive and transmit power states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PWR_FULL = 2'h0,
      PWR_HALF = 2'h1,
      PWR_OFF  = 2'h2
   } llpe_pwr_t;

endpackage

// *** hw/llpe_event_sources.sv ***
// Link-layer performance event sources with four APB-visible counters.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module llpe_event_sources (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               pkt_valid,
   input  wire logic [19:0]        pkt_header,
   input  wire logic               spawn_valid,
   input  wire logic               spawn_candidate,
   input  wire logic               spawn_credit_ok,
   input  wire logic               spawn_rbt_valid,
   input  wire logic               spawn_rbt_hit,
   input  wire logic [1:0]         rx_power_state,
   input  wire logic [1:0]         tx_power_state,
   input  wire logic               rx_buffer_skip,
   input  wire logic [5:0]         credit_port_a,
   input  wire logic [5:0]         credit_port_b,
   output logic                    link_tick
);
   import llpe_pkg::*;

   // ------------------------------------------------------------
   // Link clock enable, one pulse per eight pclk cycles
   // ------------------------------------------------------------
   logic [2:0] div_reg;
   logic [2:0] div_next;
   logic       tick_reg;
   logic       tick_next;

   always_comb begin
      div_next  = div_reg + 3'h1;
      tick_next = (div_reg == 3'(LINK_DIV - 1));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg  <= 3'h0;
         tick_reg <= 1'b0;
      end else begin
         div_reg  <= div_next;
         tick_reg <= tick_next;
      end
   end

   assign link_tick = tick_reg;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [31:0] sel_reg   [NUM_CTR];
   logic [31:0] sel_next  [NUM_CTR];
   logic [31:0] ctr_reg   [NUM_CTR];
   logic [31:0] ctr_next  [NUM_CTR];
   logic [31:0] filt_reg  [4];
   logic [31:0] filt_next [4];
   logic        prev_reg  [NUM_CTR];
   logic        prev_next [NUM_CTR];
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        err_reg;
   logic        err_next;
   llpe_pwr_t   rx_pwr_reg;
   llpe_pwr_t   rx_pwr_next;
   llpe_pwr_t   tx_pwr_reg;
   llpe_pwr_t   tx_pwr_next;

   // Two-stage synchronisers on the power-state inputs.
   logic [1:0] rx_s1_reg;
   logic [1:0] tx_s1_reg;

   function automatic logic [1:0] event_increment(
      input logic [31:0] sel,
      input logic        trig_a,
      input logic        trig_b,
      input logic        spawn_hit,
      input logic        off_now,
      input logic        half_now,
      input logic        full_now,
      input logic        skip_now,
      input logic [1:0]  credit_cnt,
      input logic        link_en
   );
      logic [7:0] code;
      logic       ext;
      logic [1:0] inc;
      code = sel[SEL_CODE_LSB +: 8];
      ext  = sel[SEL_EXT_BIT];
      inc  = 2'h0;
      if (link_en) begin
         unique case (code)
            CODE_TICK:    inc = {1'b0, !ext};
            CODE_TRIGGER: inc = ext ? (2'({1'b0, trig_a}) + 2'({1'b0, trig_b})) : 2'h0;
            CODE_SPAWN:   inc = {1'b0, !ext && spawn_hit};
            CODE_OFF:     inc = {1'b0, !ext && off_now};
            CODE_HALF:    inc = {1'b0, !ext && half_now};
            CODE_FULL:    inc = {1'b0, !ext && full_now};
            CODE_SKIP:    inc = {1'b0, !ext && skip_now};
            CODE_CREDIT:  inc = ext ? credit_cnt : 2'h0;
            default:      inc = 2'h0;
         endcase
      end
      return inc;
   endfunction

   // ------------------------------------------------------------
   // Event conditions
   // ------------------------------------------------------------
   logic       trig_a;
   logic       trig_b;
   logic [7:0] spawn_class;
   logic       off_now;
   logic       half_now;
   logic       full_now;
   logic [1:0] credit_cnt [NUM_CTR];

   always_comb begin
      trig_a = pkt_valid && (((pkt_header[FIRST_W-1:0] ^ filt_reg[0][FIRST_W-1:0])
               & filt_reg[1][FIRST_W-1:0]) == '0);
      trig_b = pkt_valid && (((pkt_header[SECOND_LSB +: SECOND_W] ^ filt_reg[2][SECOND_LSB +: SECOND_W])
               & filt_reg[3][SECOND_LSB +: SECOND_W]) == '0);
      spawn_class = 8'h00;
      if (spawn_valid && spawn_candidate) begin
         unique case ({spawn_credit_ok, spawn_rbt_valid, spawn_rbt_hit})
            3'b111:  spawn_class = 8'h01;
            3'b011:  spawn_class = 8'h02;
            3'b101:  spawn_class = 8'h04;
            3'b110:  spawn_class = 8'h10;
            3'b001:  spawn_class = 8'h08;
            3'b010:  spawn_class = 8'h20;
            3'b100:  spawn_class = 8'h40;
            default: spawn_class = 8'h80;
         endcase
      end
      off_now  = (rx_pwr_reg == PWR_OFF) || (tx_pwr_reg == PWR_OFF);
      half_now = (rx_pwr_reg == PWR_HALF);
      full_now = (rx_pwr_reg == PWR_FULL) || half_now;
   end

   // ------------------------------------------------------------
   // Counters, one per select register
   // ------------------------------------------------------------
   logic [1:0] inc_raw [NUM_CTR];
   logic       wr_en;
   logic       rd_en;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   generate
      for (genvar g = 0; g < NUM_CTR; g++) begin : g_ctr
         always_comb begin
            logic [7:0] um;
            um = sel_reg[g][SEL_UMASK_LSB +: 8];
            credit_cnt[g] = 2'(((credit_port_a & um[5:0]) != '0))
                          + 2'(((credit_port_b & um[5:0]) != '0));
            inc_raw[g] = event_increment(sel_reg[g], trig_a, trig_b, (spawn_class & um) != '0,
                                         off_now, half_now, full_now, rx_buffer_skip,
                                         credit_cnt[g], tick_reg);
            prev_next[g] = tick_reg ? (inc_raw[g] != 2'h0) : prev_reg[g];
            ctr_next[g]  = ctr_reg[g];
            sel_next[g]  = sel_reg[g];
            if (sel_reg[g][SEL_EN_BIT]) begin
               if (sel_reg[g][SEL_EDGE_BIT])
                  ctr_next[g] = ctr_reg[g] + 32'((tick_reg && inc_raw[g] != 2'h0 && !prev_reg[g]));
               else
                  ctr_next[g] = ctr_reg[g] + 32'(inc_raw[g]);
            end
            if (wr_en && paddr == ADDR_SEL0 + 8'(4 * g))
               sel_next[g] = pwdata;
            if (wr_en && paddr == ADDR_CTR0 + 8'(4 * g))
               ctr_next[g] = pwdata;
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   always_comb begin
      rdata_next = 32'h0000_0000;
      err_next   = 1'b1;
      for (int i = 0; i < 4; i++) begin
         filt_next[i] = filt_reg[i];
         if (paddr == ADDR_FILT0 + 8'(4 * i)) begin
            err_next   = 1'b0;
            rdata_next = filt_reg[i];
            if (wr_en)
               filt_next[i] = pwdata;
         end
      end
      for (int i = 0; i < NUM_CTR; i++) begin
         if (paddr == ADDR_SEL0 + 8'(4 * i)) begin
            err_next   = 1'b0;
            rdata_next = sel_reg[i];
         end
         if (paddr == ADDR_CTR0 + 8'(4 * i)) begin
            err_next   = 1'b0;
            rdata_next = ctr_reg[i];
         end
      end
      if (paddr == ADDR_STATUS) begin
         err_next   = 1'b0;
         rdata_next = {28'h0, tx_pwr_reg, rx_pwr_reg};
      end
      if (!(psel && !penable)) begin
         rdata_next = rdata_reg;
         err_next   = err_reg;
      end
      rx_pwr_next = llpe_pwr_t'(rx_s1_reg == 2'h3 ? 2'h2 : rx_s1_reg);
      tx_pwr_next = llpe_pwr_t'(tx_s1_reg == 2'h3 ? 2'h2 : tx_s1_reg);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_CTR; i++) begin
            sel_reg[i]  <= SEL_RESET;
            ctr_reg[i]  <= CTR_RESET;
            prev_reg[i] <= 1'b0;
         end
         for (int i = 0; i < 4; i++)
            filt_reg[i] <= FILT_RESET;
         rdata_reg  <= 32'h0000_0000;
         err_reg    <= 1'b0;
         rx_s1_reg  <= 2'h0;
         tx_s1_reg  <= 2'h0;
         rx_pwr_reg <= PWR_FULL;
         tx_pwr_reg <= PWR_FULL;
      end else begin
         for (int i = 0; i < NUM_CTR; i++) begin
            sel_reg[i]  <= sel_next[i];
            ctr_reg[i]  <= ctr_next[i];
            prev_reg[i] <= prev_next[i];
         end
         for (int i = 0; i < 4; i++)
            filt_reg[i] <= filt_next[i];
         rdata_reg  <= rdata_next;
         err_reg    <= err_next;
         rx_s1_reg  <= rx_power_state;
         tx_s1_reg  <= tx_power_state;
         rx_pwr_reg <= rx_pwr_next;
         tx_pwr_reg <= tx_pwr_next;
      end
   end

   assign pready  = 1'b1;
   assign prdata  = rdata_reg;
   assign pslverr = psel && penable && err_reg;

endmodule // llpe_event_sources

// *** test/llpe_event_sources_assertions.sv ***
// Port-level checker for the link-layer event block.
`timescale 1ns/10ps
module llpe_event_sources_assertions
   import llpe_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic [1:0]  rx_power_state,
   input wire logic [1:0]  tx_power_state,
   input wire logic        link_tick
);
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [2:0] age_reg;
   logic [2:0] age_next;
   always_comb begin
      age_next = (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         age_reg <= 3'h0;
      end else begin
         age_reg <= ($stable(rx_power_state) && $stable(tx_power_state)) ? age_next : 3'h0;
      end
   end
   wire st_rd = psel && !penable && !pwrite && paddr == ADDR_STATUS && age_reg == 3'h7;
   a_tick_period: assert property (link_tick |=> !link_tick [*7] ##1 link_tick)
      else $error("link tick spacing wrong");
   a_status_rx: assert property (st_rd |=> prdata[1:0] == ($past(rx_power_state) == 2'h3 ? 2'h2 : $past(rx_power_state)))
      else $error("receive state misreported");
   a_status_tx: assert property (st_rd |=> prdata[3:2] == ($past(tx_power_state) == 2'h3 ? 2'h2 : $past(tx_power_state)))
      else $error("transmit state misreported");
   a_unmapped_err: assert property (psel && penable && paddr > ADDR_STATUS |-> pslverr)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (psel && penable && paddr <= ADDR_STATUS && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
   a_err_phase: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_read_hold: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data moved outside setup");
   c_tick: cover property (link_tick);
   c_refused: cover property (psel && penable && pslverr);
   c_status: cover property (st_rd);
endmodule // llpe_event_sources_assertions

bind llpe_event_sources llpe_event_sources_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .prdata, .pslverr, .rx_power_state, .tx_power_state, .link_tick);

// *** test/llpe_event_sources_tb.sv ***
// Self-checking bench for the link-layer event block.
`timescale 1ns/10ps
module llpe_event_sources_tb;
   import llpe_pkg::*;
   // ------------------------------------------------------------
   // Signals and helpers
   // ------------------------------------------------------------
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, link_tick, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [42:0] stim;
   logic [2:0]  sp [8] = '{3'h7, 3'h3, 3'h5, 3'h1, 3'h6, 3'h2, 3'h4, 3'h0};
   int          n_fail, samples_checked;
   llpe_event_sources u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pkt_valid(stim[42]),
      .pkt_header(stim[41:22]), .spawn_valid(stim[21]), .spawn_candidate(stim[20]), .spawn_credit_ok(stim[19]),
      .spawn_rbt_valid(stim[18]), .spawn_rbt_hit(stim[17]), .rx_power_state(stim[16:15]),
      .tx_power_state(stim[14:13]), .rx_buffer_skip(stim[12]), .credit_port_a(stim[11:6]),
      .credit_port_b(stim[5:0]), .link_tick(link_tick));
   function automatic logic [42:0] pk(logic [19:0] h); return {1'b1, h, 22'h0}; endfunction
   function automatic logic [42:0] spw(logic [4:0] s); return {21'h0, s, 17'h0}; endfunction
   function automatic logic [42:0] pw(logic [1:0] r, logic [1:0] t); return {26'h0, r, t, 13'h0}; endfunction
   function automatic logic [42:0] cr(logic [5:0] c); return {31'h0, c, c}; endfunction
   function automatic logic [31:0] sl(logic [7:0] code, logic [7:0] um, logic e, logic x);
      return 32'h0040_0000 | (32'(x) << SEL_EXT_BIT) | (32'(e) << SEL_EDGE_BIT) | {16'h0, um, code};
   endfunction
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic sync_tick;
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (link_tick !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_fail++;
         wrap_up;
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_fail++;
         wrap_up;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic meas(int c, logic [31:0] s, logic [42:0] on, logic [42:0] off, int n, logic [31:0] exp);
      logic [31:0] a;
      stim <= off;
      apb(1'b1, 8'(4 * c), s);
      repeat (2) sync_tick;
      apb(1'b0, 8'(16 + 4 * c), 32'h0);
      a = rd;
      stim <= on;
      repeat (n) sync_tick;
      @(posedge pclk);
      stim <= off;
      repeat (2) sync_tick;
      apb(1'b0, 8'(16 + 4 * c), 32'h0);
      chk(rd - a, exp);
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, stim, n_fail, samples_checked} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int r = 0; r < 13; r++) begin
         apb(1'b0, 8'(4 * r), 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b0, 8'h34, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test registers done");
      meas(3, sl(CODE_TICK, 8'h0, 1'b0, 1'b0), '0, '0, 4, 6);
      meas(3, sl(CODE_TICK, 8'h0, 1'b0, 1'b1), '0, '0, 4, 0);
      apb(1'b1, ADDR_FILT0, 32'h22345);
      apb(1'b1, ADDR_FILT0 + 8'h4, 32'hfffff);
      apb(1'b1, ADDR_FILT0 + 8'h8, 32'ha0000);
      apb(1'b1, ADDR_FILT0 + 8'hc, 32'hfffff);
      meas(1, sl(CODE_TRIGGER, 8'h0, 1'b0, 1'b1), pk(20'ha2345), '0, 4, 8);
      meas(1, sl(CODE_TRIGGER, 8'h0, 1'b0, 1'b1), pk(20'h62345), '0, 4, 4);
      meas(1, sl(CODE_TRIGGER, 8'h0, 1'b0, 1'b1), pk(20'ha0000), '0, 4, 4);
      meas(1, sl(CODE_TRIGGER, 8'h0, 1'b1, 1'b1), pk(20'ha2345), '0, 4, 1);
      meas(1, sl(CODE_TRIGGER, 8'h0, 1'b0, 1'b0), pk(20'ha2345), '0, 4, 0);
      $display("test trigger done");
      for (int i = 0; i < 8; i++) begin
         meas(i % 4, sl(CODE_SPAWN, 8'(1 << i), 1'b0, 1'b0), spw({2'h3, sp[i]}), '0, 4, 4);
         meas(i % 4, sl(CODE_SPAWN, 8'(1 << i), 1'b0, 1'b0), spw({2'h3, sp[(i + 1) % 8]}), '0, 4, 0);
         meas(i % 4, sl(CODE_SPAWN, 8'(1 << i), 1'b0, 1'b0), spw({2'h2, sp[i]}), '0, 4, 0);
      end
      $display("test spawn done");
      meas(0, sl(CODE_OFF, 8'h0, 1'b0, 1'b0), pw(2'h0, 2'h2), '0, 4, 4);
      meas(0, sl(CODE_OFF, 8'h0, 1'b1, 1'b0), pw(2'h2, 2'h0), '0, 4, 1);
      meas(1, sl(CODE_HALF, 8'h0, 1'b0, 1'b0), pw(2'h1, 2'h0), pw(2'h2, 2'h0), 4, 4);
      meas(1, sl(CODE_HALF, 8'h0, 1'b0, 1'b0), pw(2'h0, 2'h0), pw(2'h2, 2'h0), 4, 0);
      meas(2, sl(CODE_FULL, 8'h0, 1'b0, 1'b0), pw(2'h1, 2'h0), pw(2'h2, 2'h0), 4, 4);
      stim <= pw(2'h1, 2'h2);
      repeat (2) sync_tick;
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h9);
      meas(2, sl(CODE_SKIP, 8'h0, 1'b0, 1'b0), 43'h1000, '0, 4, 4);
      $display("test power and skip done");
      for (int j = 0; j < 6; j++) begin
         meas(j % 4, sl(CODE_CREDIT, 8'(1 << j), 1'b0, 1'b1), cr(6'(1 << j)), '0, 4, 8);
         meas(j % 4, sl(CODE_CREDIT, 8'(1 << ((j + 1) % 6)), 1'b0, 1'b1), cr(6'(1 << j)), '0, 4, 0);
      end
      $display("test credit done");
      wrap_up;
   end
endmodule // llpe_event_sources_tb
